// *** adcrc_consts.svh ***
// Register map, field positions and reset values of the converter control block
`ifndef ADCRC_CONSTS_SVH
`define ADCRC_CONSTS_SVH

`define ADCRC_CSR_ADDR      8'h70
`define ADCRC_UPPER_ADDR    8'h71
`define ADCRC_LOWER_ADDR    8'h72
`define ADCRC_IRQ_STAT_ADDR 8'h73
`define ADCRC_IRQ_MASK_ADDR 8'h74

`define ADCRC_EOC_BIT       7
`define ADCRC_SPEED_BIT     6
`define ADCRC_PWR_BIT       5
`define ADCRC_CH_MSB        3
`define ADCRC_CH_LSB        0
`define ADCRC_IRQ_DONE_BIT  0

`define ADCRC_REG_RESET     8'h00
`define ADCRC_RES_RESET     10'h000
`define ADCRC_SAR_FIRST     10'h200
`define ADCRC_BIT_FIRST     4'h9

`define ADCRC_DIV_SLOW      2'h3
`define ADCRC_DIV_FAST      2'h1

`endif

// *** adcrc_pkg.sv ***
// Types shared by the converter control block
package adcrc_pkg;
   typedef enum logic [1:0] {
      ADCRC_OFF,
      ADCRC_SAMPLE,
      ADCRC_RESOLVE
   } adcrc_state_type;
   typedef logic [7:0] adcrc_byte_type;
   typedef logic [9:0] adcrc_result_type;
endpackage

// *** adcrc_clkdiv.sv ***
// Converter clock tick generator, one tick every two or four CPU clocks
`timescale 1ns/100ps
`include "adcrc_consts.svh"
module adcrc_clkdiv (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Control
   input  wire logic run,
   input  wire logic half_rate,
   input  wire logic phase_clear,
   // Tick out
   output logic      tick
);
   import adcrc_pkg::*;

   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic [1:0] limit;

   always_comb begin
      limit = half_rate ? `ADCRC_DIV_FAST : `ADCRC_DIV_SLOW;
      tick  = run && !phase_clear && (cnt_q == limit);
      if (!run || phase_clear || tick) begin
         cnt_d = 2'h0;
      end else begin
         cnt_d = cnt_q + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// *** adcrc_top.sv ***
// Converter control: registers, SAR sequencer, channel select and interrupt
//
// Function
// - Set done flag; clear on upper read/CSR write
// - Done flag reads one only after completion
// - Control bits writable; done flag read-only
// - Speed bit picks divide-by-four or divide-by-two
// - Power bit starts or stops conversion
// - Channel field selects input by binary code
// - Connected input count is build parameter
// - Upper result holds result bits nine-two
// - Lower result holds bits one-zero, rest zero
// - Five consecutive addresses, all reset zero
// - Converts continuously while powered on
// - Channel change aborts, clears flag, restarts
`timescale 1ns/100ps
`include "adcrc_consts.svh"
module adcrc_top #(
   parameter int NUM_CHANNELS = 16,
   parameter int SAMPLE_TICKS = 4
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      nrst,
   // Register port
   input  wire logic [7:0]                reg_addr,
   input  wire adcrc_pkg::adcrc_byte_type reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output adcrc_pkg::adcrc_byte_type      reg_rdata,
   // Analog front end
   output logic                           converter_power_on,
   output logic [3:0]                     input_channel_select,
   output logic                           channel_valid,
   output logic                           sample_hold,
   output adcrc_pkg::adcrc_result_type    dac_code,
   input  wire logic                      cmp_above,
   // Interrupt
   output logic                           irq
);
   import adcrc_pkg::*;

   localparam logic [4:0] NUM_CH_W   = 5'(NUM_CHANNELS);
   localparam logic [3:0] SMP_LAST_W = 4'(SAMPLE_TICKS - 1);

   adcrc_state_type  state_q;
   adcrc_state_type  state_d;
   logic             eoc_q;
   logic             eoc_d;
   logic             speed_q;
   logic             speed_d;
   logic             power_q;
   logic             power_d;
   logic [3:0]       ch_q;
   logic [3:0]       ch_d;
   logic [3:0]       smp_cnt_q;
   logic [3:0]       smp_cnt_d;
   logic [3:0]       bit_q;
   logic [3:0]       bit_d;
   adcrc_result_type sar_q;
   adcrc_result_type sar_d;
   adcrc_result_type result_q;
   adcrc_result_type result_d;
   adcrc_result_type sar_final;
   logic             stat_q;
   logic             stat_d;
   logic             mask_q;
   logic             mask_d;
   adcrc_byte_type   rdata_q;
   adcrc_byte_type   rdata_d;
   logic             wr_csr;
   logic             rd_upper;
   logic             ch_change;
   logic             start;
   logic             restart;
   logic             done;
   logic             tick;
   logic             div_run;

   // Bus decode
   always_comb begin
      wr_csr    = reg_wr && (reg_addr == `ADCRC_CSR_ADDR);
      rd_upper  = reg_rd && (reg_addr == `ADCRC_UPPER_ADDR);
      ch_change = wr_csr && (reg_wdata[`ADCRC_CH_MSB:`ADCRC_CH_LSB] != ch_q);
      start     = wr_csr && reg_wdata[`ADCRC_PWR_BIT] && !power_q;
   end

   // Control fields; the done flag is not part of this write path
   always_comb begin
      speed_d = speed_q;
      power_d = power_q;
      ch_d    = ch_q;
      if (wr_csr) begin
         speed_d = reg_wdata[`ADCRC_SPEED_BIT];
         power_d = reg_wdata[`ADCRC_PWR_BIT];
         ch_d    = reg_wdata[`ADCRC_CH_MSB:`ADCRC_CH_LSB];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         speed_q <= 1'b0;
         power_q <= 1'b0;
         ch_q    <= 4'h0;
      end else begin
         speed_q <= speed_d;
         power_q <= power_d;
         ch_q    <= ch_d;
      end
   end

   // Divider phase restarts with each new conversion so sample time is exact
   assign restart = start || (ch_change && power_d);
   assign div_run = (state_q != ADCRC_OFF) && power_d;

   adcrc_clkdiv u_clkdiv (
      .clk         (clk),
      .nrst        (nrst),
      .run         (div_run),
      .half_rate   (speed_q),
      .phase_clear (restart),
      .tick        (tick)
   );

   // SAR sequencer: sample window, then one result bit per converter tick
   always_comb begin
      state_d   = state_q;
      smp_cnt_d = smp_cnt_q;
      bit_d     = bit_q;
      sar_d     = sar_q;
      done      = 1'b0;
      sar_final = sar_q;
      if (!cmp_above) begin
         sar_final[bit_q] = 1'b0;
      end
      if (!power_d) begin
         state_d   = ADCRC_OFF;
         smp_cnt_d = 4'h0;
         sar_d     = `ADCRC_RES_RESET;
      end else if (restart) begin
         state_d   = ADCRC_SAMPLE;
         smp_cnt_d = 4'h0;
         sar_d     = `ADCRC_RES_RESET;
      end else begin
         unique case (state_q)
            ADCRC_OFF: begin
               state_d   = ADCRC_SAMPLE;
               smp_cnt_d = 4'h0;
            end
            ADCRC_SAMPLE: begin
               if (tick) begin
                  if (smp_cnt_q == SMP_LAST_W) begin
                     state_d = ADCRC_RESOLVE;
                     sar_d   = `ADCRC_SAR_FIRST;
                     bit_d   = `ADCRC_BIT_FIRST;
                  end else begin
                     smp_cnt_d = smp_cnt_q + 4'h1;
                  end
               end
            end
            ADCRC_RESOLVE: begin
               if (tick) begin
                  sar_d = sar_final;
                  if (bit_q == 4'h0) begin
                     done      = 1'b1;
                     state_d   = ADCRC_SAMPLE;
                     smp_cnt_d = 4'h0;
                  end else begin
                     bit_d               = bit_q - 4'h1;
                     sar_d[bit_q - 4'h1] = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q   <= ADCRC_OFF;
         smp_cnt_q <= 4'h0;
         bit_q     <= 4'h0;
         sar_q     <= `ADCRC_RES_RESET;
      end else begin
         state_q   <= state_d;
         smp_cnt_q <= smp_cnt_d;
         bit_q     <= bit_d;
         sar_q     <= sar_d;
      end
   end

   // Done flag and results; a completion beats a clear in the same cycle
   always_comb begin
      eoc_d    = eoc_q;
      result_d = result_q;
      stat_d   = stat_q;
      mask_d   = mask_q;
      if (wr_csr || rd_upper) begin
         eoc_d = 1'b0;
      end
      if (reg_wr && (reg_addr == `ADCRC_IRQ_STAT_ADDR) && reg_wdata[`ADCRC_IRQ_DONE_BIT]) begin
         stat_d = 1'b0;
      end
      if (reg_wr && (reg_addr == `ADCRC_IRQ_MASK_ADDR)) begin
         mask_d = reg_wdata[`ADCRC_IRQ_DONE_BIT];
      end
      // Result is not latched against software; the next completion overwrites it
      if (done) begin
         eoc_d    = 1'b1;
         result_d = sar_final;
         stat_d   = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eoc_q    <= 1'b0;
         result_q <= `ADCRC_RES_RESET;
         stat_q   <= 1'b0;
         mask_q   <= 1'b0;
      end else begin
         eoc_q    <= eoc_d;
         result_q <= result_d;
         stat_q   <= stat_d;
         mask_q   <= mask_d;
      end
   end

   // Read data, valid only in the cycle after the strobe
   always_comb begin
      rdata_d = `ADCRC_REG_RESET;
      if (reg_rd) begin
         unique case (reg_addr)
            `ADCRC_CSR_ADDR:      rdata_d = {eoc_q, speed_q, power_q, 1'b0, ch_q};
            `ADCRC_UPPER_ADDR:    rdata_d = result_q[9:2];
            `ADCRC_LOWER_ADDR:    rdata_d = {6'h00, result_q[1:0]};
            `ADCRC_IRQ_STAT_ADDR: rdata_d = {7'h00, stat_q};
            `ADCRC_IRQ_MASK_ADDR: rdata_d = {7'h00, mask_q};
            default:              rdata_d = `ADCRC_REG_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= `ADCRC_REG_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata            = rdata_q;
   assign converter_power_on   = power_q;
   assign input_channel_select = ch_q;
   assign channel_valid        = ({1'b0, ch_q} < NUM_CH_W);
   assign sample_hold          = (state_q == ADCRC_SAMPLE);
   assign dac_code             = sar_q;
   assign irq                  = stat_q && mask_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_csr_write_read;
      wr_csr ##1 !reg_wr ##1 (reg_rd && (reg_addr == `ADCRC_CSR_ADDR));
   endsequence

   sequence s_fast_run;
      (tick && speed_q && div_run && !restart) ##1 (speed_q && div_run && !restart)[*2];
   endsequence

   sequence s_slow_run;
      (tick && !speed_q && div_run && !restart) ##1 (!speed_q && div_run && !restart)[*4];
   endsequence

   chk_eoc_set_done: assert property (done |=> eoc_q)
      else $error("done flag not set after completion");
   chk_eoc_read_clear: assert property (rd_upper && !done |=> !eoc_q)
      else $error("upper read did not clear done flag");
   chk_eoc_cause: assert property ($rose(eoc_q) |-> $past(done))
      else $error("done flag rose without completion");
   chk_csr_readback: assert property (s_csr_write_read |=>
      (reg_rdata[6:0] == {$past(reg_wdata[6:5], 3), 1'b0, $past(reg_wdata[3:0], 3)}))
      else $error("control readback mismatch");
   chk_div_fast: assert property (s_fast_run |-> tick ##0 $past(!tick))
      else $error("fast divider period wrong");
   chk_div_slow: assert property (s_slow_run |-> tick ##0 $past(tick, 4))
      else $error("slow divider period wrong");
   chk_div_gap: assert property (tick |=> !tick)
      else $error("ticks back to back");
   chk_off_idle: assert property (!power_q |-> (state_q == ADCRC_OFF) && !tick && !done)
      else $error("converter active while off");
   chk_on_start: assert property (start |=> (state_q == ADCRC_SAMPLE) && (smp_cnt_q == 4'h0))
      else $error("power on did not start sampling");
   chk_rsvd_zero: assert property (reg_rd && (reg_addr == `ADCRC_CSR_ADDR) |=> !reg_rdata[4])
      else $error("reserved bit read nonzero");
   chk_chan_follow: assert property (wr_csr |=> input_channel_select == $past(reg_wdata[3:0]))
      else $error("channel select not updated");
   chk_chan_valid: assert property (channel_valid == (int'(input_channel_select) < NUM_CHANNELS))
      else $error("unconnected channel marked valid");
   chk_upper_map: assert property (rd_upper |=> reg_rdata == $past(result_q[9:2]))
      else $error("upper result mapping wrong");
   chk_lower_map: assert property (reg_rd && (reg_addr == `ADCRC_LOWER_ADDR) |=>
      (reg_rdata == {6'h00, $past(result_q[1:0])}))
      else $error("lower result mapping wrong");
   chk_cont_restart: assert property (done && power_q |=> (state_q == ADCRC_SAMPLE) ##1 sample_hold)
      else $error("conversion not restarted");
   chk_ch_abort: assert property (ch_change && power_d |=>
      (state_q == ADCRC_SAMPLE) && (smp_cnt_q == 4'h0) && !eoc_q)
      else $error("channel change did not abort");
   chk_result_load: assert property (done |=> eoc_q && (result_q == $past(sar_final)))
      else $error("result not loaded with flag");
endmodule

// *** adcrc_testbench.sv ***
// Self-checking testbench for the converter control block
`timescale 1ns/100ps
module testbench;
   import adcrc_pkg::*;
   localparam int NCH = 12;
   localparam int SMP = 3;

   logic             clk       = 1'b0;
   logic             nrst      = 1'b0;
   logic [7:0]       reg_addr  = 8'h00;
   adcrc_byte_type   reg_wdata = 8'h00;
   logic             reg_wr    = 1'b0;
   logic             reg_rd    = 1'b0;
   logic             cmp_above = 1'b0;
   adcrc_byte_type   reg_rdata;
   logic             pwr_on;
   logic [3:0]       ch_sel;
   logic             ch_valid;
   logic             s_hold;
   adcrc_result_type dac;
   logic             irq;
   adcrc_result_type ana       = 10'h000;
   adcrc_result_type ana_old;
   adcrc_byte_type   rv;
   int               n_fail    = 0;
   int               cmp_count = 0;
   int               cyc       = 0;
   int               t_start   = 0;
   int               n;
   logic             spd;
   logic [3:0]       ch;

   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Registered comparator; dac_code never moves faster than every second clock, so the lag is harmless
   always @(posedge clk) cmp_above <= (ana >= dac);

   adcrc_top #(.NUM_CHANNELS(NCH), .SAMPLE_TICKS(SMP)) dut_u (
      .clk                  (clk),
      .nrst                 (nrst),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .converter_power_on   (pwr_on),
      .input_channel_select (ch_sel),
      .channel_valid        (ch_valid),
      .sample_hold          (s_hold),
      .dac_code             (dac),
      .cmp_above            (cmp_above),
      .irq                  (irq)
   );

   function automatic int conv_len(input logic s);
      return (s ? 2 : 4) * (SMP + 10);
   endfunction

   function automatic adcrc_byte_type csr_val(input logic eoc, input logic s, input logic on, input logic [3:0] c);
      return {eoc, s, on, 1'b0, c};
   endfunction

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input adcrc_byte_type d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd_check(input string nm, input logic [7:0] a, input adcrc_byte_type exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      rv = reg_rdata;
      check(nm, {8'h00, rv}, {8'h00, exp});
   endtask

   // Timing is measured in edges from the edge that took the write
   task automatic start_conv(input adcrc_byte_type d);
      wr(8'h70, d);
      #1;
      t_start = cyc;
      check("sample phase", {15'h0000, s_hold}, 16'h0001);
   endtask

   task automatic wait_done(output int len);
      while (irq !== 1'b1 && cyc - t_start < 400) begin
         @(posedge clk);
         #1;
      end
      len = cyc - t_start;
      t_start = cyc;
   endtask

   task automatic read_result(input adcrc_result_type v);
      rd_check("result lower", 8'h72, {6'h00, v[1:0]});
      rd_check("result upper", 8'h71, v[9:2]);
   endtask

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(8 * 20000);
      n_fail++;
      test_done;
   end

   initial begin
      void'($urandom(32'h76FE));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (int a = 8'h70; a <= 8'h74; a++) begin
         rd_check("reset value", 8'(a), 8'h00);
      end
      wr(8'h71, 8'hFF);
      wr(8'h72, 8'hFF);
      rd_check("upper read only", 8'h71, 8'h00);
      rd_check("lower read only", 8'h72, 8'h00);
      rd_check("unmapped read", 8'h80, 8'h00);
      // Reserved bit kept clear by software; the done flag bit is written high but must stay low
      wr(8'h70, 8'hEF);
      rd_check("csr all ones", 8'h70, 8'h6F);
      wr(8'h70, 8'h00);
      // Channel sweep with the converter off, so no conversion is disturbed
      for (int c = 0; c < 16; c++) begin
         wr(8'h70, {4'h0, 4'(c)});
         #1;
         check("channel select", {12'h000, ch_sel}, 16'(c));
         check("channel valid", {15'h0000, ch_valid}, {15'h0000, c < NCH});
      end
      wr(8'h74, 8'h01);
      for (int t = 0; t < 6; t++) begin
         ana = (t == 0) ? 10'h3FF : (t == 1) ? 10'h000 : 10'($urandom);
         spd = (t < 2) ? t[0] : 1'($urandom);
         ch  = 4'($urandom);
         start_conv(csr_val(1'b0, spd, 1'b1, ch));
         rd_check("flag before done", 8'h70, csr_val(1'b0, spd, 1'b1, ch));
         wait_done(n);
         check("conversion time", 16'(n), 16'(conv_len(spd)));
         ana_old = ana;
         ana = 10'($urandom);
         read_result(ana_old);
         rd_check("flag after upper read", 8'h70, csr_val(1'b0, spd, 1'b1, ch));
         rd_check("irq status", 8'h73, 8'h01);
         wr(8'h73, 8'h01);
         #1;
         check("irq cleared", {15'h0000, irq}, 16'h0000);
         wait_done(n);
         check("repeat conversion time", 16'(n), 16'(conv_len(spd)));
         rd_check("flag set", 8'h70, csr_val(1'b1, spd, 1'b1, ch));
         // Same value rewritten while the flag is up, so only the write can clear it
         wr(8'h70, csr_val(1'b0, spd, 1'b1, ch));
         rd_check("flag after csr write", 8'h70, csr_val(1'b0, spd, 1'b1, ch));
         read_result(ana);
         // Channel change in mid-conversion restarts the count from the write
         repeat (5) @(posedge clk);
         start_conv(csr_val(1'b0, spd, 1'b1, ch ^ 4'h1));
         wr(8'h73, 8'h01);
         rd_check("flag after change", 8'h70, csr_val(1'b0, spd, 1'b1, ch ^ 4'h1));
         wait_done(n);
         check("restart time", 16'(n), 16'(conv_len(spd)));
         read_result(ana);
         repeat (7) @(posedge clk);
         wr(8'h70, csr_val(1'b0, spd, 1'b0, ch));
         wr(8'h73, 8'h01);
         #1;
         check("power off", {15'h0000, pwr_on}, 16'h0000);
         check("dac idle", {6'h00, dac}, 16'h0000);
         check("sample idle", {15'h0000, s_hold}, 16'h0000);
         repeat (conv_len(spd) * 2) @(posedge clk);
         #1;
         check("no conversion when off", {15'h0000, irq}, 16'h0000);
      end
      // Masked completion sets status but keeps the interrupt low
      wr(8'h74, 8'h00);
      start_conv(csr_val(1'b0, 1'b0, 1'b1, 4'h2));
      repeat (conv_len(1'b0) + 4) @(posedge clk);
      #1;
      check("masked irq", {15'h0000, irq}, 16'h0000);
      rd_check("masked status", 8'h73, 8'h01);
      wr(8'h74, 8'h01);
      #1;
      check("unmasked irq", {15'h0000, irq}, 16'h0001);
      test_done;
   end
endmodule
